// file: hw/bcr_pkg.sv
// Package with register map, field positions, reset values and timing of the control bank.
package bcr_pkg;
  // Register offsets on the 8-bit processor port.
  localparam logic [7:0] OFS_CH2_BYTE   = 8'h36;
  localparam logic [7:0] OFS_B1CAP_STC  = 8'h37;
  localparam logic [7:0] OFS_B2CAP_FC1  = 8'h38;
  localparam logic [7:0] OFS_FC2        = 8'h39;
  localparam logic [7:0] OFS_MON        = 8'h3A;
  localparam logic [7:0] OFS_AUX_CTRL   = 8'h3C;
  localparam logic [7:0] OFS_AUX_STAT   = 8'h3D;
  // Values after reset.
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [7:0] FLAG_PATTERN   = 8'h7E;
  // Sync transfer control fields.
  localparam int STC_TBA_LSB = 5;
  localparam int STC_TSF     = 4;
  localparam int STC_ST1     = 3;
  localparam int STC_ST0     = 2;
  localparam int STC_SC1     = 1;
  localparam int STC_SC0     = 0;
  // Feature control 1 fields.
  localparam int FC1_WTC_A   = 7;
  localparam int FC1_WTC_B   = 6;
  localparam int FC1_TEM     = 5;
  localparam int FC1_PFS     = 4;
  localparam int FC1_OFF     = 3;
  localparam int FC1_CSEL_LSB = 1;
  localparam int FC1_ITF     = 0;
  // Feature control 2 fields.
  localparam int FC2_IMS     = 7;
  localparam int FC2_S2_LSB  = 4;
  localparam int FC2_ODS     = 3;
  localparam int FC2_S1_LSB  = 0;
  // Auxiliary control fields (bit 0 high selects non-terminal timing).
  localparam int AUX_SPM     = 0;
  localparam int AUX_RSS     = 1;
  localparam int AUX_C2_IC   = 2;
  localparam int AUX_B1_CAP  = 3;
  // Auxiliary status fields.
  localparam int AST_SIN_BIT = 0;
  localparam int AST_SOV_BIT = 1;
  localparam int AST_SAW_BIT = 2;
  localparam int AST_WOV_BIT = 3;
  // Backplane frame geometry in bit periods.
  localparam logic [7:0] MID_TERMINAL = 8'h30;
  localparam logic [7:0] MID_NONTERM  = 8'h80;
  localparam logic [2:0] IC_CHANNEL_TERMINAL = 3'h2;
  // Timing.
  localparam int CLK_MHZ        = 100;
  localparam int WDOG_MS        = 128;
  localparam int WDOG_CYCLES    = WDOG_MS * 1000 * CLK_MHZ;
  localparam int PF_SHORT_NS    = 520;
  localparam int PF_LONG_NS     = 910;
  localparam int PF_SHORT_CYC   = (PF_SHORT_NS * CLK_MHZ + 999) / 1000;
  localparam int PF_LONG_CYC    = (PF_LONG_NS * CLK_MHZ + 999) / 1000;

  // Event inputs from the monitor channel handshake logic, one bit per channel.
  typedef struct packed {
    logic [1:0] byteRx;
    logic [1:0] firstByte;
    logic [1:0] endRx;
    logic [1:0] ack;
    logic [1:0] abort;
    logic [1:0] protoMr;
    logic [1:0] protoMx;
  } bcr_mon_s;

  // Backplane pin drive.
  typedef struct packed {
    logic dataOut;
    logic dataOe_b;
    logic strobe1;
    logic strobe2;
    logic released;
  } bcr_pins_s;
endpackage

// file: hw/bcr_aux_regs.sv
// Auxiliary control register bank with backplane frame timing, watchdog and strobes.
// What this block does
// - Terminal mode: channel-2 byte reads/writes B2 or IC2; B1 capture holds B1.
// - Terminal functions on: awake pin input only; falling edge sets awake flag.
// - Terminal functions, reset source zero: awake fall or code change pulses reset.
// - Reset source one: only watchdog expiry pulses reset.
// - Terminal-functions enable clears only on hardware reset.
// - Three-bit bus access address sets arbitration priority.
// - Frame-start sync bit raises sync interrupt at each frame start.
// - Mid-frame sync bit raises sync interrupt at each frame middle.
// - Frame-start transfer not acknowledged before mid-frame raises sync overflow.
// - Mid-frame transfer not acknowledged before next start raises sync overflow.
// - Watchdog runs with both bits; write 1,0 then 0,1 within 128 ms.
// - Watchdog expiry raises watchdog overflow flag and reset pulse.
// - Test and prefilter bits select none, 520 ns, 910 ns or layer-1 off.
// - Terminal mode backplane-off releases all backplane pins; internals run on.
// - Non-terminal mode channel select picks one of eight channels.
// - Between frames send ones, or flags 01111110 when fill bit set.
// - Mode bit one enables the data strobe controls.
// - Strobe codes: x00 low, B1/B2/both, IC1/IC2/both; IC is channel+1 in non-terminal mode, channel 2 in terminal mode.
// - Driver bit one gives tristate drivers, zero gives open drain.
// - Monitor status reports received, end, acknowledge, abort per channel.
// - Receive enable unmasks received/end; transmit enable unmasks acknowledge/abort.
// - Receive control zero: handshake bit one, only first byte reported.
// - Transmit control zero holds transmit handshake bit one, else protocol.
`timescale 1ns/100ps
`default_nettype none

module bcr_aux_regs #(
  parameter logic [23:0] WDOG_CYCLES = 24'(bcr_pkg::WDOG_CYCLES)
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              ce,
  input  wire logic [7:0]        addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wrStb,
  input  wire logic              rdStb,
  output logic [7:0]             rdata,
  input  wire logic              dataClkPin,
  input  wire logic              frameSyncPin,
  input  wire logic              dataInPin,
  input  wire logic              awakePin,
  input  wire logic              ciCodeChange,
  input  wire bcr_pkg::bcr_mon_s monIn,
  output bcr_pkg::bcr_pins_s     pins,
  output logic                   resetPulse,
  output logic [2:0]             busAccessAddr,
  output logic                   layer1Disable,
  output logic [7:0]             prefilterCycles,
  output logic                   fillBit,
  output logic [1:0]             rxHandshake,
  output logic [1:0]             txHandshake
);

  // Byte slot decode: bit counter lies in the given byte of the given channel.
  function automatic logic slotHit(input logic [7:0] cnt, input logic [2:0] ch,
                                   input logic slot);
    slotHit = (cnt[7:3] == {ch, 1'b0, slot});
  endfunction

  // Strobe decode for one three-bit control value and the current slot flags.
  function automatic logic strobeOn(input logic [2:0] code, input logic [3:0] hits);
    logic [1:0] sel;
    sel = code[2] ? hits[3:2] : hits[1:0];
    strobeOn = (code[0] & sel[0]) | (code[1] & sel[1]);
  endfunction

  logic [7:0]  stc_q;
  logic        tsf_q;
  logic [7:0]  fc1_q;
  logic [7:0]  fc2_q;
  logic [7:0]  moc_q;
  logic [7:0]  mos_q;
  logic [7:0]  mos_d;
  logic [3:0]  aux_q;
  logic [3:0]  stat_q;
  logic [3:0]  stat_d;
  logic [7:0]  ch2Tx_q;
  logic [7:0]  ch2Rx_q;
  logic [7:0]  b1Cap_q;
  logic [7:0]  b2Cap_q;
  logic [3:0]  sync1_q;
  logic [3:0]  sync2_q;
  logic [3:0]  sync3_q;
  logic [3:0]  filt_q;
  logic [3:0]  settle;
  logic [7:0]  bitCnt_q;
  logic [7:0]  shift_q;
  logic [7:0]  fill_q;
  logic        pend1_q;
  logic        pend0_q;
  logic [23:0] wdCnt_q;
  logic        wdArm_q;
  logic        resetPulse_q;

  wire terminal  = ~aux_q[bcr_pkg::AUX_SPM];
  wire rssWdog   = aux_q[bcr_pkg::AUX_RSS];
  wire wr        = ce & wrStb;
  wire rd        = ce & rdStb;

  //////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers: three stages, a level counts when stages two and three agree.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
      sync3_q <= 4'hF;
      filt_q  <= 4'hF;
    end else if (ce) begin
      sync1_q <= {awakePin, dataInPin, frameSyncPin, dataClkPin};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q  <= (filt_q & ~settle) | (sync2_q & settle);
    end
  end

  assign settle = ~(sync2_q ^ sync3_q);
  wire clkRise    = settle[0] & sync2_q[0] & ~filt_q[0];
  wire frameStart = settle[1] & sync2_q[1] & ~filt_q[1];
  wire dataBit    = filt_q[2];
  wire awakeFall  = settle[3] & ~sync2_q[3] & filt_q[3];
  wire [7:0] nextCnt = frameStart ? 8'h00 : bitCnt_q + 8'h01;
  wire [7:0] midCnt  = terminal ? bcr_pkg::MID_TERMINAL : bcr_pkg::MID_NONTERM;
  wire midFrame      = clkRise & ~frameStart & (nextCnt == midCnt);

  //////////////////////////////////////////////////////////////////////////////
  // Frame bit counter and receive shifter; the counter restarts on the frame sync edge.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bitCnt_q <= 8'h00;
      shift_q  <= 8'h00;
    end else if (ce) begin
      if (frameStart) begin
        bitCnt_q <= 8'h00;
      end else if (clkRise) begin
        bitCnt_q <= nextCnt;
      end
      if (clkRise) begin
        shift_q <= {shift_q[6:0], dataBit};
      end
    end
  end

  // Channel numbers of the B and IC slots; terminal mode uses fixed channels.
  wire [2:0] csel   = fc1_q[bcr_pkg::FC1_CSEL_LSB +: 3];
  wire [2:0] bChan  = terminal ? 3'h0 : csel;
  wire [2:0] icChan = terminal ? bcr_pkg::IC_CHANNEL_TERMINAL : 3'(csel + 3'h1);
  wire [3:0] hits   = {slotHit(bitCnt_q, icChan, 1'b1), slotHit(bitCnt_q, icChan, 1'b0),
                       slotHit(bitCnt_q, bChan, 1'b1), slotHit(bitCnt_q, bChan, 1'b0)};
  wire ch2Hit   = aux_q[bcr_pkg::AUX_C2_IC] ? hits[3] : hits[1];
  wire byteDone = clkRise & (bitCnt_q[2:0] == 3'h7);
  wire [7:0] rxByte = {shift_q[6:0], dataBit};

  //////////////////////////////////////////////////////////////////////////////
  // Slot capture; channel-2 and B1 capture only run in terminal mode.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ch2Rx_q <= bcr_pkg::RST_BYTE;
      b1Cap_q <= bcr_pkg::RST_BYTE;
      b2Cap_q <= bcr_pkg::RST_BYTE;
    end else if (ce && byteDone && terminal) begin
      if (ch2Hit) begin
        ch2Rx_q <= rxByte;
      end
      if (hits[0] && aux_q[bcr_pkg::AUX_B1_CAP]) begin
        b1Cap_q <= rxByte;
      end
      if (hits[1]) begin
        b2Cap_q <= rxByte;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration writes; terminal-functions enable is set by software and cleared only by hardware reset.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stc_q   <= bcr_pkg::RST_BYTE;
      tsf_q   <= 1'b0;
      fc1_q   <= bcr_pkg::RST_BYTE;
      fc2_q   <= bcr_pkg::RST_BYTE;
      moc_q   <= bcr_pkg::RST_BYTE;
      aux_q   <= 4'h0;
      ch2Tx_q <= bcr_pkg::RST_BYTE;
    end else if (wr) begin
      case (addr)
        bcr_pkg::OFS_CH2_BYTE:  ch2Tx_q <= wdata;
        bcr_pkg::OFS_B1CAP_STC: begin
          stc_q <= wdata;
          tsf_q <= tsf_q | wdata[bcr_pkg::STC_TSF];
        end
        bcr_pkg::OFS_B2CAP_FC1: fc1_q <= wdata;
        bcr_pkg::OFS_FC2:       fc2_q <= wdata;
        bcr_pkg::OFS_MON:       moc_q <= wdata;
        bcr_pkg::OFS_AUX_CTRL:  aux_q <= wdata[3:0];
        default:                aux_q <= aux_q;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog: a write of 1,0 arms, a following write of 0,1 restarts the count.
  wire wdRun    = tsf_q & rssWdog;
  wire fc1Write = wr & (addr == bcr_pkg::OFS_B2CAP_FC1);
  wire wdKick   = fc1Write & wdArm_q & ~wdata[bcr_pkg::FC1_WTC_A] & wdata[bcr_pkg::FC1_WTC_B];
  wire wdExpire = ce & wdRun & ~wdKick & (wdCnt_q == WDOG_CYCLES - 24'h1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdCnt_q <= 24'h0;
      wdArm_q <= 1'b0;
    end else if (ce) begin
      if (!wdRun || wdKick || wdExpire) begin
        wdCnt_q <= 24'h0;
      end else begin
        wdCnt_q <= wdCnt_q + 24'h1;
      end
      if (fc1Write) begin
        wdArm_q <= wdata[bcr_pkg::FC1_WTC_A] & ~wdata[bcr_pkg::FC1_WTC_B];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sync transfer bookkeeping; an acknowledge is a write with the completion bit at one.
  wire stcWrite = wr & (addr == bcr_pkg::OFS_B1CAP_STC);
  wire ack1     = stcWrite & wdata[bcr_pkg::STC_SC1];
  wire ack0     = stcWrite & wdata[bcr_pkg::STC_SC0];
  wire sinSet   = (frameStart & stc_q[bcr_pkg::STC_ST1]) | (midFrame & stc_q[bcr_pkg::STC_ST0]);
  wire sovSet   = (midFrame & pend1_q & ~ack1) | (frameStart & pend0_q & ~ack0);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend1_q <= 1'b0;
      pend0_q <= 1'b0;
    end else if (ce) begin
      if (frameStart && stc_q[bcr_pkg::STC_ST1]) begin
        pend1_q <= 1'b1;
      end else if (ack1 || midFrame) begin
        pend1_q <= 1'b0;
      end
      if (midFrame && stc_q[bcr_pkg::STC_ST0]) begin
        pend0_q <= 1'b1;
      end else if (ack0 || frameStart) begin
        pend0_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sticky status; cleared by reading it, a set in the same cycle wins.
  wire sawSet = tsf_q & awakeFall;
  wire rdStat = rd & (addr == bcr_pkg::OFS_AUX_STAT);
  wire rdMon  = rd & (addr == bcr_pkg::OFS_MON);

  always_comb begin
    stat_d = rdStat ? 4'h0 : stat_q;
    stat_d[bcr_pkg::AST_SIN_BIT] = stat_d[bcr_pkg::AST_SIN_BIT] | sinSet;
    stat_d[bcr_pkg::AST_SOV_BIT] = stat_d[bcr_pkg::AST_SOV_BIT] | sovSet;
    stat_d[bcr_pkg::AST_SAW_BIT] = stat_d[bcr_pkg::AST_SAW_BIT] | sawSet;
    stat_d[bcr_pkg::AST_WOV_BIT] = stat_d[bcr_pkg::AST_WOV_BIT] | wdExpire;
  end

  // Monitor flags: receive enable gates received/end, transmit enable gates ack/abort.
  always_comb begin
    mos_d = rdMon ? 8'h00 : mos_q;
    for (int c = 0; c < 2; c++) begin
      mos_d[4*c+3] = mos_d[4*c+3] | (moc_q[4*c+3] & monIn.byteRx[c]
                     & (moc_q[4*c+2] | monIn.firstByte[c]));
      mos_d[4*c+2] = mos_d[4*c+2] | (moc_q[4*c+3] & monIn.endRx[c]);
      mos_d[4*c+1] = mos_d[4*c+1] | (moc_q[4*c+1] & monIn.ack[c]);
      mos_d[4*c]   = mos_d[4*c] | (moc_q[4*c+1] & monIn.abort[c]);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_q <= 4'h0;
      mos_q  <= bcr_pkg::RST_BYTE;
    end else if (ce) begin
      stat_q <= stat_d;
      mos_q  <= mos_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset pulse source: awake or code change, or the watchdog alone.
  wire wakeEvent = tsf_q & ~rssWdog & (awakeFall | ciCodeChange);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resetPulse_q <= 1'b0;
    end else if (ce) begin
      resetPulse_q <= wakeEvent | wdExpire;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port: data stand in the cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= 8'h00;
      if (rd) begin
        case (addr)
          bcr_pkg::OFS_CH2_BYTE:  rdata <= terminal ? ch2Rx_q : 8'h00;
          bcr_pkg::OFS_B1CAP_STC: rdata <= terminal ? b1Cap_q : 8'h00;
          bcr_pkg::OFS_B2CAP_FC1: rdata <= terminal ? b2Cap_q : 8'h00;
          bcr_pkg::OFS_FC2:       rdata <= fc2_q;
          bcr_pkg::OFS_MON:       rdata <= mos_q;
          bcr_pkg::OFS_AUX_CTRL:  rdata <= {3'h0, tsf_q, aux_q};
          bcr_pkg::OFS_AUX_STAT:  rdata <= {4'h0, stat_q};
          default:                rdata <= 8'h00;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Backplane drive. Open drain only pulls low; the switch-off bit releases everything
  // but the slot timing keeps running, so re-enabling needs no resync.
  wire offBit   = terminal & fc1_q[bcr_pkg::FC1_OFF];
  wire txBit    = ch2Tx_q[3'h7 - bitCnt_q[2:0]];
  wire txSlot   = terminal & ch2Hit & ~offBit;
  wire imsOn    = fc2_q[bcr_pkg::FC2_IMS];
  wire [2:0] s1 = fc2_q[bcr_pkg::FC2_S1_LSB +: 3];
  wire [2:0] s2 = fc2_q[bcr_pkg::FC2_S2_LSB +: 3];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pins <= '{dataOut: 1'b1, dataOe_b: 1'b1, strobe1: 1'b0, strobe2: 1'b0, released: 1'b0};
    end else if (ce) begin
      pins.dataOut  <= fc2_q[bcr_pkg::FC2_ODS] ? txBit : 1'b0;
      pins.dataOe_b <= ~(txSlot & (fc2_q[bcr_pkg::FC2_ODS] | ~txBit));
      pins.strobe1  <= imsOn & ~offBit & strobeOn(s1, hits);
      pins.strobe2  <= imsOn & ~offBit & strobeOn(s2, hits);
      pins.released <= offBit;
    end
  end

  // Inter-frame fill: ones, or the flag pattern rotated out one bit per data clock.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fill_q  <= bcr_pkg::FLAG_PATTERN;
      fillBit <= 1'b1;
    end else if (ce && clkRise) begin
      fill_q  <= {fill_q[6:0], fill_q[7]};
      fillBit <= fc1_q[bcr_pkg::FC1_ITF] ? fill_q[7] : 1'b1;
    end
  end

  // Static control outputs and handshake bits.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busAccessAddr   <= 3'h0;
      layer1Disable   <= 1'b0;
      prefilterCycles <= 8'h00;
      rxHandshake     <= 2'h3;
      txHandshake     <= 2'h3;
    end else if (ce) begin
      busAccessAddr <= stc_q[bcr_pkg::STC_TBA_LSB +: 3];
      layer1Disable <= fc1_q[bcr_pkg::FC1_TEM] & ~fc1_q[bcr_pkg::FC1_PFS];
      case ({fc1_q[bcr_pkg::FC1_TEM], fc1_q[bcr_pkg::FC1_PFS]})
        2'b01:   prefilterCycles <= 8'(bcr_pkg::PF_SHORT_CYC);
        2'b11:   prefilterCycles <= 8'(bcr_pkg::PF_LONG_CYC);
        default: prefilterCycles <= 8'h00;
      endcase
      for (int c = 0; c < 2; c++) begin
        rxHandshake[c] <= moc_q[4*c+2] ? monIn.protoMr[c] : 1'b1;
        txHandshake[c] <= moc_q[4*c] ? monIn.protoMx[c] : 1'b1;
      end
    end
  end

  assign resetPulse = resetPulse_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_TSF_STICKY: assert property (tsf_q |=> tsf_q)
    else $error("terminal functions enable dropped");
  AST_SAW_SET: assert property (ce && tsf_q && awakeFall |=> stat_q[bcr_pkg::AST_SAW_BIT])
    else $error("awake flag not set");
  AST_RST_WAKE: assert property (ce && tsf_q && !rssWdog && awakeFall |=> resetPulse)
    else $error("awake edge gave no reset pulse");
  AST_RST_WDOG_ONLY: assert property (ce && tsf_q && rssWdog && !wdExpire |=> !resetPulse)
    else $error("reset pulse without watchdog expiry");
  AST_SIN_START: assert property (ce && frameStart && stc_q[bcr_pkg::STC_ST1]
    |=> stat_q[bcr_pkg::AST_SIN_BIT])
    else $error("no sync interrupt at frame start");
  AST_SIN_MID: assert property (ce && midFrame && stc_q[bcr_pkg::STC_ST0]
    |=> stat_q[bcr_pkg::AST_SIN_BIT])
    else $error("no sync interrupt at mid frame");
  AST_SOV_START: assert property (ce && midFrame && pend1_q && !ack1
    |=> stat_q[bcr_pkg::AST_SOV_BIT])
    else $error("missed overflow for frame-start transfer");
  AST_SOV_MID: assert property (ce && frameStart && pend0_q && !ack0
    |=> stat_q[bcr_pkg::AST_SOV_BIT])
    else $error("missed overflow for mid-frame transfer");
  AST_WDOG_EXPIRE: assert property (wdExpire
    |=> stat_q[bcr_pkg::AST_WOV_BIT] && resetPulse ##1 !resetPulse)
    else $error("watchdog expiry not signalled as one pulse");
  AST_STROBE_GATE: assert property (ce && !imsOn |=> !pins.strobe1 && !pins.strobe2)
    else $error("strobe active outside strobe mode");
  AST_MDR_MASK: assert property (ce && !moc_q[3] && !mos_q[3] |=> !mos_q[3])
    else $error("masked receive status was set");
  AST_RX_HSK_IDLE: assert property (ce && !moc_q[2] |=> rxHandshake[0])
    else $error("receive handshake not held at one");
  AST_OFF_RELEASE: assert property (ce && offBit |=> pins.dataOe_b && pins.released)
    else $error("backplane driven while switched off");

  COV_WDOG: cover property (wdExpire);
  COV_SOV: cover property (ce && sovSet);
  COV_CH2: cover property (ce && byteDone && terminal && ch2Hit);
  COV_MDR: cover property (ce && rdMon ##1 mos_q == 8'h00);

endmodule // bcr_aux_regs

`default_nettype wire

// file: dv/bcr_backplane_model.sv
// Backplane peripheral model that drives data clock, frame sync and receive data.
`timescale 1ns/100ps
`default_nettype none

module bcr_backplane_model (
  output logic dataClk,
  output logic frameSync,
  output logic dataIn
);
  // The clock stands still low between frames; sync rises before the first clock rise.
  initial begin
    dataClk = 1'b0;
    frameSync = 1'b0;
    dataIn = 1'b1;
  end

  // One frame, MSB first: the first byte carries b1Byte, later bits are ones.
  task automatic send_frame(input logic [7:0] b1Byte, input int nBits);
    logic bitVal;
    bitVal = 1'b1;
    for (int i = 0; i < nBits; i++) begin
      bitVal = (i < 8) ? b1Byte[7 - i] : 1'b1;
      dataIn = bitVal;
      frameSync = (i < 2);
      #80 dataClk = 1'b1;
      #80 dataClk = 1'b0;
    end
    frameSync = 1'b0;
    dataIn = ~bitVal; // A released line must not keep showing the last bit.
  endtask
endmodule // bcr_backplane_model

`default_nettype wire

// file: dv/tb_bcr_aux_regs.sv
// Self-checking testbench of the auxiliary control register bank.
`timescale 1ns/100ps
`default_nettype none

module tb_bcr_aux_regs;
  localparam logic [23:0] WDOG = 24'h0000C8; // Shortened watchdog, 200 cycles.
  logic               clk = 1'b0;
  logic               rst_b = 1'b0;
  logic [7:0]         addr = 8'h00;
  logic [7:0]         wdata = 8'h00;
  logic               wrStb = 1'b0;
  logic               rdStb = 1'b0;
  logic [7:0]         rdata;
  logic               awakePin = 1'b1;
  logic               ciCodeChange = 1'b0;
  bcr_pkg::bcr_mon_s  monIn = '0;
  bcr_pkg::bcr_pins_s pins;
  logic               resetPulse;
  logic [2:0]         busAccessAddr;
  logic               layer1Disable;
  logic [7:0]         prefilterCycles;
  logic               fillBit;
  logic [1:0]         rxHandshake;
  logic [1:0]         txHandshake;
  wire logic          dataClk;
  wire logic          frameSync;
  wire logic          dataIn;
  int                 num_errors = 0;
  int                 tests_run = 0;
  int                 cycles = 0;
  logic [7:0]         got;
  logic               seen;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, device and far-side model.
  always #5 clk = ~clk;

  bcr_aux_regs #(.WDOG_CYCLES(WDOG)) bcr_aux_regs_i (
    .clk(clk), .rst_b(rst_b), .ce(1'b1), .addr(addr), .wdata(wdata), .wrStb(wrStb),
    .rdStb(rdStb), .rdata(rdata), .dataClkPin(dataClk), .frameSyncPin(frameSync),
    .dataInPin(dataIn), .awakePin(awakePin), .ciCodeChange(ciCodeChange), .monIn(monIn),
    .pins(pins), .resetPulse(resetPulse), .busAccessAddr(busAccessAddr),
    .layer1Disable(layer1Disable), .prefilterCycles(prefilterCycles),
    .fillBit(fillBit), .rxHandshake(rxHandshake), .txHandshake(txHandshake));

  bcr_backplane_model bcr_backplane_model_i (
    .dataClk(dataClk), .frameSync(frameSync), .dataIn(dataIn));

  ////////////////////////////////////////////////////////////////////////////////
  // Bus cycles and comparison helpers.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] val);
    tests_run++;
    if (val !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, val);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 got = rdata;
  endtask

  // Let two edges pass so registered outputs have landed.
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic watch_reset(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1 if (resetPulse === 1'b1) seen = 1'b1;
    end
  endtask

  task automatic mon_pulse(input bcr_pkg::bcr_mon_s ev);
    @(posedge clk);
    monIn <= ev;
    @(posedge clk);
    monIn <= '0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_regs();
    rd(8'h39); chk("fc2 reset", 8'h00, got);
    wr(8'h39, 8'hA5);
    rd(8'h39); chk("fc2", 8'hA5, got);
    wr(8'h3B, 8'hFF);
    rd(8'h3B); chk("unmapped", 8'h00, got);
    wr(8'h38, 8'h08);
    settle(); chk("released", 8'h01, {7'h00, pins.released});
  endtask

  // Walk all four test/prefilter codes.
  task automatic t_prefilter();
    logic [7:0] expCyc [4];
    expCyc = '{8'h00, 8'(bcr_pkg::PF_SHORT_CYC), 8'h00, 8'(bcr_pkg::PF_LONG_CYC)};
    for (int i = 0; i < 4; i++) begin
      wr(8'h38, 8'(i << 4));
      settle();
      chk("prefilter", expCyc[i], prefilterCycles);
      chk("layer1 off", {7'h00, i == 2}, {7'h00, layer1Disable});
    end
  endtask

  // No frame-start acknowledge is given, so overflow must follow the interrupt.
  task automatic t_sync();
    wr(8'h3C, 8'h08);
    wr(8'h37, 8'hE8);
    wr(8'h38, 8'h01);
    settle(); chk("bus addr", 8'h07, {5'h00, busAccessAddr});
    bcr_backplane_model_i.send_frame(8'hA5, 64);
    repeat (10) @(posedge clk);
    // After 64 data clocks the flag pattern has shifted out its last bit, a zero.
    chk("fill flag", 8'h00, {7'h00, fillBit});
    rd(8'h3D); chk("sync status", 8'h03, got);
    rd(8'h37); chk("b1 capture", 8'hA5, got);
  endtask

  task automatic t_monitor();
    bcr_pkg::bcr_mon_s ev;
    ev = '0;
    ev.endRx = 2'b01;
    mon_pulse(ev);
    rd(8'h3A); chk("mon masked", 8'h00, got);
    wr(8'h3A, 8'h08);
    mon_pulse(ev);
    rd(8'h3A); chk("mon end", 8'h04, got);
    ev = '0;
    ev.byteRx = 2'b01;
    mon_pulse(ev);
    rd(8'h3A); chk("mon later byte", 8'h00, got);
    ev.firstByte = 2'b01;
    mon_pulse(ev);
    rd(8'h3A); chk("mon first byte", 8'h08, got);
    chk("handshake fixed", 8'h0F, {4'h0, rxHandshake, txHandshake});
    wr(8'h3A, 8'h05);
    settle(); chk("handshake proto", 8'h0A, {4'h0, rxHandshake, txHandshake});
  endtask

  // Awake edges, then the watchdog with one restart before expiry.
  task automatic t_awake_wdog();
    wr(8'h37, 8'h10);
    @(posedge clk) awakePin <= 1'b0;
    watch_reset(20); chk("awake reset", 8'h01, {7'h00, seen});
    rd(8'h3D); chk("awake flag", 8'h04, got);
    @(posedge clk) awakePin <= 1'b1;
    @(posedge clk) ciCodeChange <= 1'b1;
    @(posedge clk) ciCodeChange <= 1'b0;
    #1 seen = resetPulse;
    chk("code reset", 8'h01, {7'h00, seen});
    wr(8'h3C, 8'h02);
    wr(8'h37, 8'h00);
    rd(8'h3C); chk("tsf kept", 8'h10, got & 8'h10);
    @(posedge clk) begin
      awakePin <= 1'b0;
      ciCodeChange <= 1'b1;
    end
    @(posedge clk) ciCodeChange <= 1'b0;
    watch_reset(20); chk("awake ignored", 8'h00, {7'h00, seen});
    rd(8'h3D); chk("awake flag wd", 8'h04, got);
    @(posedge clk) awakePin <= 1'b1;
    repeat (60) @(posedge clk);
    wr(8'h38, 8'h80);
    wr(8'h38, 8'h40);
    watch_reset(150); chk("wdog restarted", 8'h00, {7'h00, seen});
    watch_reset(100); chk("wdog expiry", 8'h01, {7'h00, seen});
    rd(8'h3D); chk("wdog flag", 8'h08, got);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, hang guard and main sequence.
  task automatic report_and_stop();
    if (num_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      report_and_stop();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_prefilter();
    t_sync();
    t_monitor();
    t_awake_wdog();
    report_and_stop();
  end
endmodule // tb_bcr_aux_regs

`default_nettype wire
